/* File: pkg/base_cfg_pkg.sv */
// Constants and types for the base decode and configuration block.
`default_nettype none
package base_cfg_pkg;

   // ---------------------------------------------------------------
   // Window base address register
   // ---------------------------------------------------------------
   localparam logic [31:0] BASE_REG_ADDR   = 32'h0003ff00;
   localparam logic [3:0]  FC_CPU_SPACE    = 4'h7;
   localparam logic [31:0] BASE_RESET      = 32'h00000000;
   localparam logic [31:0] BASE_WR_MASK    = 32'hfffff3ff;
   localparam int          BASE_ADDR_LSB   = 12;
   localparam int          SPACE_MASK_LSB  = 1;
   localparam int          SPACE_MASK_W    = 9;
   localparam int          VALID_BIT       = 0;

   // ---------------------------------------------------------------
   // Module configuration register
   // ---------------------------------------------------------------
   localparam logic [11:0] CFG_OFFSET      = 12'h000;
   localparam logic [15:0] CFG_RESET       = 16'h608f;
   localparam logic [15:0] CFG_WR_MASK     = 16'h738f;
   localparam int          FRZ_TIMERS_BIT  = 14;
   localparam int          FRZ_BUSMON_BIT  = 13;
   localparam int          FULL_IRQ_BIT    = 12;
   localparam int          SHOW_SEL_LSB    = 8;
   localparam int          SUPERVISOR_RESTRICT_BIT        = 7;
   localparam int          ARB_PRIO_LSB    = 0;

   // ---------------------------------------------------------------
   // Function codes and port B roles
   // ---------------------------------------------------------------
   localparam logic [3:0]  FC_SUPERVISOR_RESTRICT_DATA    = 4'h5;
   localparam int          FC_SUPERVISOR_RESTRICT_BIT     = 2;
   localparam logic [6:0]  IRQ_ALL_LINES   = 7'h7f;
   localparam logic [6:0]  IRQ_FOUR_LINES  = 7'h0f;
   localparam logic [3:0]  CS_ALL_LINES    = 4'hf;

   typedef enum logic [1:0] {
      SHOW_OFF_ARB_ON  = 2'h0,
      SHOW_ON_ARB_OFF  = 2'h1,
      SHOW_ON_ARB_ON   = 2'h2,
      SHOW_ON_ARB_ON_B = 2'h3
   } show_sel_type;

endpackage
`default_nettype wire

/* File: pkg/show_cycle_if.sv */
// Carrier between the decoder and the show-cycle sequencer.
`default_nettype none
interface show_cycle_if;
   logic        start;
   logic [31:0] addr;
   logic [31:0] data;
   logic [3:0]  fc;
   logic        we;
   logic        busy;

   modport ctrl (output start, addr, data, fc, we, input busy);
   modport seq  (input start, addr, data, fc, we, output busy);
endinterface
`default_nettype wire

/* File: hw/show_cycle_seq.sv */
// Show-cycle sequencer that mirrors internal transfers on the pins.
`default_nettype none
module show_cycle_seq
   import base_cfg_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys_i,
   input  wire logic        reset_i,
   // Request carrier
   show_cycle_if.seq        sh,
   // External bus pins
   output logic [31:0]      ext_addr_o,
   output logic             ext_addr_oe_o,
   output logic [31:0]      ext_data_o,
   output logic             ext_data_oe_o,
   output logic [3:0]       ext_fc_o,
   output logic             ext_rw_o,
   output logic             ext_as_n_o,
   output logic             ext_ds_n_o
);

   typedef enum logic [2:0] {S_IDLE, S_ADDR, S_STRB, S_NEG, S_HOLD}
      seq_state_type;

   seq_state_type state_q;

   // ---------------------------------------------------------------
   // Sequence
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         state_q <= S_IDLE;
      end else begin
         case (state_q)
            S_IDLE:  if (sh.start) state_q <= S_ADDR;
            S_ADDR:  state_q <= S_STRB;
            S_STRB:  state_q <= S_NEG;
            S_NEG:   state_q <= S_HOLD;
            S_HOLD:  state_q <= S_IDLE;
            default: state_q <= S_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         ext_addr_o <= 32'h00000000;
         ext_data_o <= 32'h00000000;
         ext_fc_o   <= 4'h0;
         ext_rw_o   <= 1'b1;
      end else if (state_q == S_IDLE && sh.start) begin
         ext_addr_o <= sh.addr;
         ext_data_o <= sh.data;
         ext_fc_o   <= sh.fc;
         ext_rw_o   <= !sh.we;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         ext_addr_oe_o <= 1'b0;
         ext_data_oe_o <= 1'b0;
         ext_ds_n_o    <= 1'b1;
      end else begin
         ext_addr_oe_o <= (state_q == S_IDLE) ? sh.start
                          : (state_q != S_HOLD);
         ext_data_oe_o <= (state_q == S_ADDR) || (state_q == S_STRB)
                          || (state_q == S_NEG);
         ext_ds_n_o    <= !(state_q == S_ADDR);
      end
   end

   assign ext_as_n_o = 1'b1;
   assign sh.busy    = (state_q != S_IDLE);

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_show_as_idle: assert property (@(posedge clk_sys_i)
      disable iff (reset_i) ext_as_n_o)
      else $error("Address strobe asserted during show cycle.");

   a_data_after_ds: assert property (@(posedge clk_sys_i)
      disable iff (reset_i)
      $rose(ext_ds_n_o) |-> ext_data_oe_o ##1 ext_data_oe_o)
      else $error("Show data not held after strobe negation.");

   a_ds_with_addr: assert property (@(posedge clk_sys_i)
      disable iff (reset_i)
      !ext_ds_n_o |-> ext_addr_oe_o && $past(ext_addr_oe_o))
      else $error("Data strobe without driven address.");

endmodule
`default_nettype wire

/* File: hw/base_decode_config.sv */
// Relocatable window decode and top-level configuration register.
//
// Summary of operation
// - Base field bits 31..12 place 4K window.
// - Base register only at CPU space 7.
// - Set mask bit sends that space external.
// - Top mask bit codes 1xxx, rest 7..0.
// - Window closed until valid flag set.
// - Base register access never runs externally.
// - Configuration register: supervisor access only, user access errors.
// - Freeze with timer bit halts timers.
// - Freeze with monitor bit disables bus monitor.
// - Full-irq bit: seven irqs, else four+four.
// - Show cycle drives bus, data strobe times.
// - Show data valid after strobe negation.
// - No show cycles means nothing driven.
// - Show select decodes show and arbitration.
// - Bus requests ignored while arbitration off.
// - Supervisor bit: user writes refused, error.
// - Arbitration field resets F, zero discards.
`default_nettype none
module base_decode_config
   import base_cfg_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys_i,
   input  wire logic        reset_i,
   // Processor access
   input  wire logic        cpu_req_i,
   input  wire logic        cpu_we_i,
   input  wire logic [3:0]  cpu_fc_i,
   input  wire logic [31:0] cpu_addr_i,
   input  wire logic [31:0] cpu_wdata_i,
   output logic [31:0]      cpu_rdata_o,
   output logic             cpu_ack_o,
   output logic             cpu_bus_error_signal_o,
   output logic             cpu_ext_o,
   // Other window registers
   output logic             periph_sel_o,
   output logic [11:0]      periph_ofs_o,
   // Debug freeze and monitors
   input  wire logic        freeze_i,
   output logic             timers_halt_o,
   output logic             busmon_disable_o,
   // Port B roles
   output logic [6:0]       portb_irq_en_o,
   output logic [3:0]       portb_cs_en_o,
   output logic             portb_autovec_o,
   // Interrupt arbitration
   output logic [3:0]       arb_priority_o,
   output logic             arb_enable_o,
   // External bus arbitration
   input  wire logic        ext_bus_req_i,
   output logic             ext_bus_req_seen_o,
   output logic             ext_arb_enable_o,
   output logic             show_enable_o,
   // External bus pins for show cycles
   output logic [31:0]      ext_addr_o,
   output logic             ext_addr_oe_o,
   output logic [31:0]      ext_data_o,
   output logic             ext_data_oe_o,
   output logic [3:0]       ext_fc_o,
   output logic             ext_rw_o,
   output logic             ext_as_n_o,
   output logic             ext_ds_n_o
);

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [31:0] base_q;
   logic [15:0] cfg_q;
   logic [31:0] rdata_q;
   logic        ack_q;
   logic        bus_error_signal_q;
   logic        ext_q;
   logic        periph_q;
   logic [11:0] periph_ofs_q;
   logic        freeze_s1_q;
   logic        freeze_s2_q;
   logic        busreq_s1_q;
   logic        busreq_s2_q;

   show_cycle_if sh ();

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   logic [19:0]              base_field;
   logic [SPACE_MASK_W-1:0]  space_mask;
   logic                     base_valid;
   logic                     space_masked;
   logic                     base_hit;
   logic                     win_hit;
   logic                     cfg_hit;
   logic                     user_access;
   logic                     supervisor_restrict_refuse;
   logic                     cfg_refuse;
   show_sel_type             show_sel;
   logic                     show_en;
   logic                     arb_en;

   assign base_field = base_q[31:BASE_ADDR_LSB];
   assign space_mask = base_q[SPACE_MASK_LSB +: SPACE_MASK_W];
   assign base_valid = base_q[VALID_BIT];

   always_comb begin
      if (cpu_fc_i[3]) begin
         space_masked = space_mask[SPACE_MASK_W-1];
      end else begin
         space_masked = space_mask[cpu_fc_i[2:0]];
      end
   end

   assign base_hit = (cpu_fc_i == FC_CPU_SPACE)
                     && (cpu_addr_i == BASE_REG_ADDR);

   assign win_hit = !base_hit && base_valid && !space_masked
                    && (cpu_addr_i[31:BASE_ADDR_LSB] == base_field);

   assign cfg_hit     = win_hit
                        && (cpu_addr_i[11:2] == CFG_OFFSET[11:2]);
   assign user_access = !cpu_fc_i[FC_SUPERVISOR_RESTRICT_BIT];
   assign cfg_refuse  = cfg_hit && user_access;
   assign supervisor_restrict_refuse = win_hit && !cfg_hit && cpu_we_i
                        && user_access && cfg_q[SUPERVISOR_RESTRICT_BIT];

   assign show_sel = show_sel_type'(cfg_q[SHOW_SEL_LSB +: 2]);

   always_comb begin
      case (show_sel)
         SHOW_OFF_ARB_ON: begin
            show_en = 1'b0;
            arb_en  = 1'b1;
         end
         SHOW_ON_ARB_OFF: begin
            show_en = 1'b1;
            arb_en  = 1'b0;
         end
         default: begin
            show_en = 1'b1;
            arb_en  = 1'b1;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Base register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         base_q <= BASE_RESET;
      end else if (cpu_req_i && cpu_we_i && base_hit) begin
         base_q <= cpu_wdata_i & BASE_WR_MASK;
      end
   end

   // ---------------------------------------------------------------
   // Configuration register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         cfg_q <= CFG_RESET;
      end else if (cpu_req_i && cpu_we_i && cfg_hit && !cfg_refuse) begin
         cfg_q <= cpu_wdata_i[15:0] & CFG_WR_MASK;
      end
   end

   // ---------------------------------------------------------------
   // Access answer
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         ack_q    <= 1'b0;
         bus_error_signal_q   <= 1'b0;
         ext_q    <= 1'b0;
         periph_q <= 1'b0;
      end else begin
         ack_q    <= cpu_req_i && (base_hit
                     || (cfg_hit && !cfg_refuse));
         bus_error_signal_q   <= cpu_req_i && (supervisor_restrict_refuse || cfg_refuse);
         ext_q    <= cpu_req_i && !base_hit && !win_hit;
         periph_q <= cpu_req_i && win_hit && !cfg_hit && !supervisor_restrict_refuse;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         rdata_q      <= 32'h00000000;
         periph_ofs_q <= 12'h000;
      end else if (cpu_req_i) begin
         periph_ofs_q <= cpu_addr_i[11:0];
         if (base_hit) begin
            rdata_q <= base_q;
         end else if (cfg_hit && !cfg_refuse) begin
            rdata_q <= {16'h0000, cfg_q};
         end else begin
            rdata_q <= 32'h00000000;
         end
      end
   end

   assign cpu_rdata_o  = rdata_q;
   assign cpu_ack_o    = ack_q;
   assign cpu_bus_error_signal_o   = bus_error_signal_q;
   assign cpu_ext_o    = ext_q;
   assign periph_sel_o = periph_q;
   assign periph_ofs_o = periph_ofs_q;

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         freeze_s1_q <= 1'b0;
         freeze_s2_q <= 1'b0;
      end else begin
         freeze_s1_q <= freeze_i;
         freeze_s2_q <= freeze_s1_q;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         busreq_s1_q <= 1'b0;
         busreq_s2_q <= 1'b0;
      end else begin
         busreq_s1_q <= ext_bus_req_i;
         busreq_s2_q <= busreq_s1_q;
      end
   end

   // ---------------------------------------------------------------
   // Configuration outputs
   // ---------------------------------------------------------------
   assign timers_halt_o    = freeze_s2_q && cfg_q[FRZ_TIMERS_BIT];
   assign busmon_disable_o = freeze_s2_q && cfg_q[FRZ_BUSMON_BIT];

   assign portb_irq_en_o  = cfg_q[FULL_IRQ_BIT] ? IRQ_ALL_LINES
                            : IRQ_FOUR_LINES;
   assign portb_cs_en_o   = cfg_q[FULL_IRQ_BIT] ? 4'h0
                            : CS_ALL_LINES;
   assign portb_autovec_o = cfg_q[FULL_IRQ_BIT];

   assign arb_priority_o = cfg_q[ARB_PRIO_LSB +: 4];
   assign arb_enable_o   = (cfg_q[ARB_PRIO_LSB +: 4] != 4'h0);

   assign ext_arb_enable_o   = arb_en;
   assign show_enable_o      = show_en;
   assign ext_bus_req_seen_o = busreq_s2_q && arb_en;

   // ---------------------------------------------------------------
   // Show cycles
   // ---------------------------------------------------------------
   assign sh.start = cpu_req_i && win_hit && show_en
                     && !sh.busy && !supervisor_restrict_refuse && !cfg_refuse;
   assign sh.addr  = cpu_addr_i;
   assign sh.data  = cpu_we_i ? cpu_wdata_i
                     : (cfg_hit ? {16'h0000, cfg_q} : 32'h00000000);
   assign sh.fc    = cpu_fc_i;
   assign sh.we    = cpu_we_i;

   show_cycle_seq u_show (
      .clk_sys_i     (clk_sys_i),
      .reset_i       (reset_i),
      .sh            (sh),
      .ext_addr_o    (ext_addr_o),
      .ext_addr_oe_o (ext_addr_oe_o),
      .ext_data_o    (ext_data_o),
      .ext_data_oe_o (ext_data_oe_o),
      .ext_fc_o      (ext_fc_o),
      .ext_rw_o      (ext_rw_o),
      .ext_as_n_o    (ext_as_n_o),
      .ext_ds_n_o    (ext_ds_n_o)
   );

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_base_stays_inside: assert property (@(posedge clk_sys_i)
      disable iff (reset_i)
      cpu_req_i && base_hit && !sh.busy |=> cpu_ack_o && !cpu_ext_o
      && !ext_addr_oe_o)
      else $error("Base register access went external.");

   a_base_space_only: assert property (@(posedge clk_sys_i)
      disable iff (reset_i)
      cpu_req_i && cpu_we_i && cpu_fc_i != FC_CPU_SPACE
      && !win_hit |=> $stable(base_q))
      else $error("Base register written outside CPU space.");

   a_invalid_external: assert property (@(posedge clk_sys_i)
      disable iff (reset_i)
      cpu_req_i && !base_valid && !base_hit |=> cpu_ext_o && !cpu_ack_o)
      else $error("Window answered while base register invalid.");

   a_masked_external: assert property (@(posedge clk_sys_i)
      disable iff (reset_i)
      cpu_req_i && !base_hit && base_valid
      && cpu_addr_i[31:12] == base_q[31:12]
      && (cpu_fc_i[3] ? base_q[9] : base_q[cpu_fc_i[2:0] + 1])
      |=> cpu_ext_o && !periph_sel_o)
      else $error("Masked space decoded internally.");

   a_window_hit: assert property (@(posedge clk_sys_i)
      disable iff (reset_i)
      cpu_req_i && cpu_ext_o == 1'b0 ##1 cpu_ext_o |-> !$past(win_hit))
      else $error("Window hit went external.");

   a_freeze_timers: assert property (@(posedge clk_sys_i)
      disable iff (reset_i)
      freeze_i [*3] ##0 cfg_q[FRZ_TIMERS_BIT] |-> timers_halt_o)
      else $error("Timers not halted under freeze.");

   a_freeze_busmon: assert property (@(posedge clk_sys_i)
      disable iff (reset_i)
      !freeze_i [*3] |-> !busmon_disable_o)
      else $error("Bus monitor disabled without freeze.");

   a_portb_roles: assert property (@(posedge clk_sys_i)
      disable iff (reset_i)
      cfg_q[FULL_IRQ_BIT] |-> portb_irq_en_o == 7'h7f
      && portb_cs_en_o == 4'h0 && portb_autovec_o)
      else $error("Port B roles wrong in full interrupt mode.");

   a_no_show_drive: assert property (@(posedge clk_sys_i)
      disable iff (reset_i)
      !show_en [*5] |-> ext_ds_n_o && !ext_data_oe_o)
      else $error("Bus driven with show cycles disabled.");

   a_arb_off_ignore: assert property (@(posedge clk_sys_i)
      disable iff (reset_i)
      show_sel == SHOW_ON_ARB_OFF |-> !ext_bus_req_seen_o)
      else $error("Bus request seen while arbitration off.");

   a_user_write_err: assert property (@(posedge clk_sys_i)
      disable iff (reset_i)
      cpu_req_i && supervisor_restrict_refuse |=> cpu_bus_error_signal_o && !periph_sel_o
      && !cpu_ack_o)
      else $error("User write not refused with bus error.");

   a_cfg_reset: assert property (@(posedge clk_sys_i)
      $fell(reset_i) |-> cfg_q == 16'h608f && arb_enable_o)
      else $error("Configuration reset value wrong.");

   a_reserved_zero: assert property (@(posedge clk_sys_i)
      disable iff (reset_i)
      (cfg_q & ~CFG_WR_MASK) == 16'h0000
      && (base_q & ~BASE_WR_MASK) == 32'h00000000)
      else $error("Reserved bits hold a one.");

endmodule
`default_nettype wire

/* File: bench/ext_bus_partner.sv */
// External bus peripheral that watches show cycles and requests the bus.
`default_nettype none
module ext_bus_partner (
   // Clock
   input  wire logic        clk_sys_i,
   // Bus request control
   input  wire logic        req_want_i,
   input  wire logic        quiet_i,
   input  wire logic        rogue_i,
   output logic             ext_bus_req_o,
   // Show-cycle pins
   input  wire logic [31:0] ext_addr_i,
   input  wire logic [31:0] ext_data_i,
   input  wire logic        ext_data_oe_i,
   input  wire logic        ext_as_n_i,
   input  wire logic        ext_ds_n_i,
   // Observations
   output logic [31:0]      cap_addr_o,
   output logic [31:0]      cap_data_o,
   output logic [7:0]       show_cnt_o,
   output logic [7:0]       oe_cnt_o,
   output logic             as_seen_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic ds_low_q;

   // Stays off the bus while show cycles run unarbitrated and rogue_i is low.
   assign ext_bus_req_o = req_want_i & (~quiet_i | rogue_i);

   initial begin
      ds_low_q = 1'b0;
      cap_addr_o = 32'h0;
      cap_data_o = 32'h0;
      show_cnt_o = 8'h00;
      oe_cnt_o = 8'h00;
      as_seen_o = 1'b0;
   end

   // A floating data bus reads back inverted.
   always @(negedge clk_sys_i) begin
      if (ext_data_oe_i) begin
         oe_cnt_o <= oe_cnt_o + 8'h01;
      end
      if (!ext_as_n_i) begin
         as_seen_o <= 1'b1;
      end
      if (!ext_ds_n_i) begin
         ds_low_q <= 1'b1;
         cap_addr_o <= ext_addr_i;
      end else if (ds_low_q) begin
         ds_low_q <= 1'b0;
         cap_data_o <= ext_data_oe_i ? ext_data_i : ~ext_data_i;
         show_cnt_o <= show_cnt_o + 8'h01;
      end
   end
endmodule
`default_nettype wire

/* File: bench/base_decode_config_tb_top.sv */
// Self-checking bench for the base decode and configuration block.
`default_nettype none
module base_decode_config_tb_top import base_cfg_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [31:0] B = 32'h12345000;
   localparam logic [3:0] R_ACK = 4'h8;
   localparam logic [3:0] R_BUS_ERROR_SIGNAL = 4'h4;
   localparam logic [3:0] R_EXT = 4'h2;
   localparam logic [3:0] R_SEL = 4'h1;

   logic clk, rst, req, we, ack, bus_error_signal, ext, sel, frz, halt, bmd, av;
   logic arben, breq, seen, xarb, shen, xdoe, xas_n, xds_n;
   logic want, quiet, rogue, as_seen, xrw, xaoe;
   logic [3:0] fc, prio, fv, xfc;
   logic [31:0] addr, wd, rdata, xa, xd, cap_a, cap_d, cw;
   logic [11:0] ofs;
   logic [6:0] irq;
   logic [3:0] cs;
   logic [7:0] scnt, ocnt, c, o;
   logic [1:0] sv;
   int fail_count, n_tests;

   base_decode_config DUT (
      .clk_sys_i(clk), .reset_i(rst), .cpu_req_i(req), .cpu_we_i(we),
      .cpu_fc_i(fc), .cpu_addr_i(addr), .cpu_wdata_i(wd),
      .cpu_rdata_o(rdata), .cpu_ack_o(ack), .cpu_bus_error_signal_o(bus_error_signal),
      .cpu_ext_o(ext), .periph_sel_o(sel), .periph_ofs_o(ofs),
      .freeze_i(frz), .timers_halt_o(halt), .busmon_disable_o(bmd),
      .portb_irq_en_o(irq), .portb_cs_en_o(cs), .portb_autovec_o(av),
      .arb_priority_o(prio), .arb_enable_o(arben), .ext_bus_req_i(breq),
      .ext_bus_req_seen_o(seen), .ext_arb_enable_o(xarb),
      .show_enable_o(shen), .ext_addr_o(xa), .ext_addr_oe_o(xaoe),
      .ext_data_o(xd), .ext_data_oe_o(xdoe), .ext_fc_o(xfc),
      .ext_rw_o(xrw),
      .ext_as_n_o(xas_n), .ext_ds_n_o(xds_n));

   ext_bus_partner far_end (
      .clk_sys_i(clk), .req_want_i(want), .quiet_i(quiet),
      .rogue_i(rogue), .ext_bus_req_o(breq), .ext_addr_i(xa),
      .ext_data_i(xd), .ext_data_oe_i(xdoe), .ext_as_n_i(xas_n),
      .ext_ds_n_i(xds_n), .cap_addr_o(cap_a), .cap_data_o(cap_d),
      .show_cnt_o(scnt), .oe_cnt_o(ocnt), .as_seen_o(as_seen));

   always #2.5 clk = ~clk;

   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_resp(input logic [3:0] exp);
      chk_val({28'h0, ack, bus_error_signal, ext, sel}, {28'h0, exp});
   endtask

   task automatic acc(input logic w, input logic [3:0] f,
                      input logic [31:0] a, input logic [31:0] d,
                      input logic [3:0] exp);
      @(negedge clk);
      req = 1'b1;
      we = w;
      fc = f;
      addr = a;
      wd = d;
      @(negedge clk);
      req = 1'b0;
      chk_resp(exp);
   endtask

   task automatic rdv(input logic [3:0] f, input logic [31:0] a,
                      input logic [31:0] exp);
      acc(1'b0, f, a, 32'h0, R_ACK);
      chk_val(rdata, exp);
   endtask

   task automatic end_of_test();
      $display("TB: tests %0d failures %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic wait_show(input logic [7:0] c0);
      for (int i = 0; i < 12 && scnt === c0; i++) @(negedge clk);
      if (scnt === c0) begin
         chk_val({24'h0, scnt}, {24'h0, c0 + 8'h01});
         end_of_test();
      end
   endtask

   initial begin
      clk = 0;
      rst = 1;
      req = 0;
      we = 0;
      fc = 0;
      addr = 0;
      wd = 0;
      frz = 0;
      want = 0;
      quiet = 0;
      rogue = 0;
      fail_count = 0;
      n_tests = 0;
      repeat (4) @(negedge clk);
      rst = 0;
      // ---------------------------------------------------------------
      // Reset state and base register
      // ---------------------------------------------------------------
      chk_val({20'h0, irq, cs, av}, {20'h0, 7'h0f, 4'hf, 1'b0});
      chk_val({27'h0, prio, arben}, {27'h0, 4'hf, 1'b1});
      chk_val({29'h0, seen, xarb, shen}, 32'h2);
      acc(0, 4'h5, 32'hfffff000, 0, R_EXT);
      rdv(FC_CPU_SPACE, BASE_REG_ADDR, 32'h0);
      acc(0, 4'h6, BASE_REG_ADDR, 0, R_EXT);
      acc(1, FC_CPU_SPACE, BASE_REG_ADDR, 32'hffffffff, R_ACK);
      rdv(FC_CPU_SPACE, BASE_REG_ADDR, 32'hfffff3ff);
      acc(1, FC_CPU_SPACE, BASE_REG_ADDR, B, R_ACK);
      acc(0, 4'h5, B, 0, R_EXT);
      acc(1, FC_CPU_SPACE, BASE_REG_ADDR, B | 32'h1, R_ACK);
      rdv(4'h5, B, 32'h0000608f);
      acc(0, 4'h5, B + 32'hffc, 0, R_SEL);
      chk_val({20'h0, ofs}, 32'hffc);
      acc(0, 4'h5, B + 32'h1000, 0, R_EXT);
      acc(0, 4'h5, B - 32'h4, 0, R_EXT);
      acc(0, 4'h5, BASE_REG_ADDR, 0, R_EXT);
      // ---------------------------------------------------------------
      // Space masks for every function code
      // ---------------------------------------------------------------
      for (int k = 0; k < 9; k++) begin
         acc(1, FC_CPU_SPACE, BASE_REG_ADDR, B | 32'h1 | (32'h2 << k),
             R_ACK);
         for (int f = 0; f < 16; f++) begin
            fv = f[3:0];
            acc(0, fv, B + 32'h10, 0,
                (fv[3] ? k == 8 : k == fv[2:0]) ? R_EXT : R_SEL);
         end
      end
      acc(1, FC_CPU_SPACE, BASE_REG_ADDR, B | 32'h1, R_ACK);
      // ---------------------------------------------------------------
      // Supervisor restriction
      // ---------------------------------------------------------------
      acc(1, 4'h1, B + 32'h10, 0, R_BUS_ERROR_SIGNAL);
      acc(0, 4'h1, B + 32'h10, 0, R_SEL);
      acc(1, 4'h1, B, 32'h0, R_BUS_ERROR_SIGNAL);
      rdv(4'h5, B, 32'h0000608f);
      // ---------------------------------------------------------------
      // Configuration codes, freeze and bus request
      // ---------------------------------------------------------------
      for (int s = 0; s < 4; s++) begin
         sv = s[1:0];
         cw = {16'hffff, 1'b1, sv[0], sv[1], sv[0], 2'h3, sv, 1'b1, 3'h7,
               2'h0, sv};
         acc(1, 4'h5, B, cw, R_ACK);
         rdv(4'h5, B, cw & 32'h0000738f);
         quiet = (sv == 2'h1);
         rogue = 1;
         want = 1;
         frz = 1;
         repeat (3) @(negedge clk);
         chk_val({30'h0, halt, bmd},
                 {30'h0, sv[0], sv[1]});
         chk_val({20'h0, irq, cs, av}, {20'h0, sv[0] ? 7'h7f : 7'h0f,
                 sv[0] ? 4'h0 : 4'hf, sv[0]});
         chk_val({27'h0, prio, arben},
                 {27'h0, 2'h0, sv, sv != 2'h0});
         chk_val({29'h0, seen, xarb, shen},
                 {29'h0, sv != 2'h1, sv != 2'h1,
                  sv != 2'h0});
         frz = 0;
         repeat (3) @(negedge clk);
         chk_val({30'h0, halt, bmd}, 32'h0);
      end
      want = 0;
      rogue = 0;
      quiet = 0;
      // ---------------------------------------------------------------
      // Show cycles
      // ---------------------------------------------------------------
      repeat (8) @(negedge clk);
      c = scnt;
      acc(1, 4'h5, B + 32'h10, 32'ha5a5c3c3, R_SEL);
      wait_show(c);
      chk_val(cap_d, 32'ha5a5c3c3);
      chk_val(cap_a, B + 32'h10);
      chk_val({26'h0, xfc, xrw, xaoe}, {26'h0, 4'h5, 1'b0, 1'b1});
      chk_val({31'h0, as_seen}, 32'h0);
      repeat (6) @(negedge clk);
      c = scnt;
      acc(0, FC_CPU_SPACE, BASE_REG_ADDR, 0, R_ACK);
      acc(1, 4'h1, B + 32'h10, 0, R_BUS_ERROR_SIGNAL);
      repeat (8) @(negedge clk);
      chk_val({24'h0, scnt}, {24'h0, c});
      acc(1, 4'h5, B, 32'h0000000f, R_ACK);
      repeat (8) @(negedge clk);
      c = scnt;
      o = ocnt;
      acc(1, 4'h1, B + 32'h10, 0, R_SEL);
      acc(1, 4'h5, B, 32'h0000000f, R_ACK);
      repeat (8) @(negedge clk);
      chk_val({16'h0, scnt, ocnt}, {16'h0, c, o});
      end_of_test();
   end
endmodule
`default_nettype wire
